/* src/wdog_pkg.sv */
// Shared constants for the windowed watchdog pair
package wdog_pkg;
  // Counter geometry
  localparam int unsigned CNT_W     = 14;              // Down-counter width
  localparam int unsigned PRE_W     = 13;              // Prescaler width (ratio up to 8192)
  localparam int unsigned SEL_W     = 3;               // Prescaler select width
  // Prescaler ratios as log2, periph-clocked instance: 4,64,128,512,4096,8192
  localparam logic [3:0] PER_LOG2_0 = 4'h2;
  localparam logic [3:0] PER_LOG2_1 = 4'h6;
  localparam logic [3:0] PER_LOG2_2 = 4'h7;
  localparam logic [3:0] PER_LOG2_3 = 4'h9;
  localparam logic [3:0] PER_LOG2_4 = 4'hC;
  localparam logic [3:0] PER_LOG2_5 = 4'hD;
  // Prescaler ratios as log2, independent instance: 1,16,32,64,128,256
  localparam logic [3:0] IND_LOG2_0 = 4'h0;
  localparam logic [3:0] IND_LOG2_1 = 4'h4;
  localparam logic [3:0] IND_LOG2_2 = 4'h5;
  localparam logic [3:0] IND_LOG2_3 = 4'h6;
  localparam logic [3:0] IND_LOG2_4 = 4'h7;
  localparam logic [3:0] IND_LOG2_5 = 4'h8;
  // Timeout periods in count-clock cycles: 1024, 4096, 8192, 16384
  localparam logic [CNT_W:0] TMO_0  = 15'h0400;
  localparam logic [CNT_W:0] TMO_1  = 15'h1000;
  localparam logic [CNT_W:0] TMO_2  = 15'h2000;
  localparam logic [CNT_W:0] TMO_3  = 15'h4000;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 14'h3FFF;    // Counter initial value
  // Underflow action encoding
  localparam logic ACT_RESET = 1'b0;
  localparam logic ACT_IRQ   = 1'b1;
  // Watchdog states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_STOP = 3'b100
  } wd_state_t;

  // Prescaler log2 for one instance kind and select code
  function automatic logic [3:0] pre_log2(input logic indep, input logic [SEL_W-1:0] sel);
    logic [3:0] r;
    r = indep ? IND_LOG2_0 : PER_LOG2_0;
    unique case (sel)
      3'h1: r = indep ? IND_LOG2_1 : PER_LOG2_1;
      3'h2: r = indep ? IND_LOG2_2 : PER_LOG2_2;
      3'h3: r = indep ? IND_LOG2_3 : PER_LOG2_3;
      3'h4: r = indep ? IND_LOG2_4 : PER_LOG2_4;
      3'h5: r = indep ? IND_LOG2_5 : PER_LOG2_5;
      default: r = indep ? IND_LOG2_0 : PER_LOG2_0;
    endcase
    return r;
  endfunction : pre_log2
endpackage : wdog_pkg

/* src/wdog_core.sv */
// One windowed watchdog channel: prescaler, 14-bit down-counter, window check
`timescale 1ns/100ps
module wdog_core
  import wdog_pkg::*;
#(
  parameter bit INDEP = 1'b0                      // Selects the prescaler ratio table
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,            // One count-source edge
  input  wire logic             hold,            // Freeze counting and state
  input  wire logic             refresh,         // Software refresh pulse
  input  wire logic [SEL_W-1:0] pre_sel,         // Option: prescaler select
  input  wire logic [1:0]       tmo_sel,         // Option: timeout select
  input  wire logic [1:0]       win_start_sel,   // Option: window start (100/75/50/25 %)
  input  wire logic [1:0]       win_end_sel,     // Option: window end (0/25/50/75 %)
  input  wire logic             action,          // Option: reset or interrupt
  input  wire logic             auto_start,      // Option: start after reset
  output logic [CNT_W-1:0]      cnt_q,           // Counter value
  output logic                  running_q,       // Counting
  output logic                  underflow_q,     // Sticky underflow
  output logic                  refresh_err_q,   // Sticky refresh error
  output logic                  rst_req_q,       // Internal reset request pulse
  output logic                  irq_q            // Interrupt request pulse
);
  // Latched options, fixed after reset
  logic             cfg_loaded_q;
  logic [3:0]       log2_q;
  logic [CNT_W:0]   tmo_q;
  logic [1:0]       ws_q, we_q;
  logic             action_q, auto_q;
  wd_state_t        state_q;
  logic [PRE_W-1:0] pre_q;                        // Prescaler count
  logic [PRE_W-1:0] pre_mask;                     // Ratio minus one
  logic             step;                         // One count-clock period
  logic [CNT_W+2:0] quarter_x;                    // Scaled window bound scratch
  logic [CNT_W-1:0] win_hi, win_lo;               // Window bounds on counter
  logic             in_window;
  logic             underflow_ev, refresh_err_ev, event_any;

  // Options are straps: caught once by a clocked process after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded_q <= 1'b0;
      log2_q       <= 4'h0;
      tmo_q        <= TMO_3;
      ws_q         <= 2'h0;
      we_q         <= 2'h0;
      action_q     <= ACT_RESET;
      auto_q       <= 1'b0;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      log2_q       <= pre_log2(INDEP, pre_sel);
      unique case (tmo_sel)
        2'h0: tmo_q <= TMO_0;
        2'h1: tmo_q <= TMO_1;
        2'h2: tmo_q <= TMO_2;
        2'h3: tmo_q <= TMO_3;
      endcase
      ws_q         <= win_start_sel;
      we_q         <= win_end_sel;
      action_q     <= action;
      auto_q       <= auto_start;
    end
  end

  // Ratio decode and window bounds from the latched timeout
  always_comb begin
    pre_mask  = PRE_W'((14'h0001 << log2_q) - 14'h0001);
    step      = tick && !hold && (pre_q == pre_mask);
    quarter_x = (CNT_W+3)'(tmo_q >> 2) * (CNT_W+3)'(3'h4 - {1'b0, ws_q});
    win_hi    = CNT_W'(quarter_x - 17'h00001);
    quarter_x = (CNT_W+3)'(tmo_q >> 2) * (CNT_W+3)'({1'b0, we_q});
    win_lo    = CNT_W'(quarter_x);
    in_window = (cnt_q <= win_hi) && (cnt_q >= win_lo);
  end

  // Error events; held channel ignores refreshes as well
  assign underflow_ev   = running_q && step && (cnt_q == '0);
  assign refresh_err_ev = running_q && !hold && refresh && !in_window;
  assign event_any      = underflow_ev || refresh_err_ev;

  // Prescaler runs only while counting so each period starts clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (!running_q || (refresh && !hold)) begin
      pre_q <= '0;
    end else if (tick && !hold) begin
      pre_q <= (pre_q == pre_mask) ? '0 : pre_q + 1'b1;
    end
  end

  // Control state: idle until start, run, stop for good on an error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cfg_loaded_q && !hold && (auto_q || refresh)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (event_any) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: state_q <= ST_STOP;              // Only reset restarts
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign running_q = (state_q == ST_RUN);

  // Down-counter, reloaded on start and on a good refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else if (state_q == ST_IDLE) begin
      cnt_q <= CNT_W'(tmo_q - 15'h0001);
    end else if (running_q && !hold && refresh && in_window) begin
      cnt_q <= CNT_W'(tmo_q - 15'h0001);
    end else if (running_q && step && (cnt_q != '0)) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Sticky causes and one-cycle action pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underflow_q   <= 1'b0;
      refresh_err_q <= 1'b0;
      rst_req_q     <= 1'b0;
      irq_q         <= 1'b0;
    end else begin
      underflow_q   <= underflow_q || underflow_ev;
      refresh_err_q <= refresh_err_q || refresh_err_ev;
      rst_req_q     <= event_any && (action_q == ACT_RESET);
      irq_q         <= event_any && (action_q == ACT_IRQ);
    end
  end

  // Checks
  chk_underflow_stop: assert property (@(posedge clk) disable iff (!rst_n)
    underflow_ev |=> (state_q == ST_STOP) && underflow_q ##1 (state_q == ST_STOP))
    else $error("underflow did not stop the counter");
  chk_count_down: assert property (@(posedge clk) disable iff (!rst_n)
    (running_q && step && cnt_q != '0 && !refresh) |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("counter did not step down by one");
  chk_hold_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (running_q && hold) |=> $stable(cnt_q) && running_q)
    else $error("held channel changed");
  chk_auto_start: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(cfg_loaded_q) && auto_q && !hold) |=> running_q)
    else $error("auto start did not begin counting");
  chk_reg_start_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE && cfg_loaded_q && !auto_q && !refresh) |=> state_q == ST_IDLE)
    else $error("register start began without refresh");
  chk_window_error: assert property (@(posedge clk) disable iff (!rst_n)
    refresh_err_ev |=> refresh_err_q && !running_q ##1 (rst_req_q || irq_q) == 1'b0)
    else $error("refresh outside window not flagged");
  chk_action_route: assert property (@(posedge clk) disable iff (!rst_n)
    event_any |=> (rst_req_q == (action_q == ACT_RESET)) && (irq_q == (action_q == ACT_IRQ)))
    else $error("wrong underflow action");
  chk_options_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_loaded_q |=> $stable(tmo_q) && $stable(log2_q) && $stable(action_q))
    else $error("options changed after reset");
  cov_underflow: cover property (@(posedge clk) disable iff (!rst_n) underflow_ev);
  cov_good_refresh: cover property (@(posedge clk) disable iff (!rst_n)
    running_q && refresh && in_window && !hold);
  cov_refresh_err: cover property (@(posedge clk) disable iff (!rst_n) refresh_err_ev);
endmodule : wdog_core

/* src/wdog_pair.sv */
// Top: peripheral-clocked and independent windowed watchdogs
`timescale 1ns/100ps
module wdog_pair
  import wdog_pkg::*;
(
  // Clock and reset
  input  wire logic             CLK_IN,
  input  wire logic             RESET_N_IN,
  // Independent channel count source, slower than CLK_IN / 2
  input  wire logic             INDEPENDENT_WATCHDOG_CLOCK_IN,
  // System controls
  input  wire logic             ALL_MODULE_STOP_IN,
  input  wire logic             PER_REFRESH_IN,
  input  wire logic             IND_REFRESH_IN,
  // Option settings, periph channel
  input  wire logic [SEL_W-1:0] PER_PRE_SEL_IN,
  input  wire logic [1:0]       PER_TMO_SEL_IN,
  input  wire logic [1:0]       PER_WIN_START_IN,
  input  wire logic [1:0]       PER_WIN_END_IN,
  input  wire logic             PER_ACTION_IN,
  input  wire logic             PER_AUTO_START_IN,
  // Option settings, independent channel
  input  wire logic [SEL_W-1:0] IND_PRE_SEL_IN,
  input  wire logic [1:0]       IND_TMO_SEL_IN,
  input  wire logic [1:0]       IND_WIN_START_IN,
  input  wire logic [1:0]       IND_WIN_END_IN,
  input  wire logic             IND_ACTION_IN,
  input  wire logic             IND_AUTO_START_IN,
  input  wire logic             IND_STOP_ON_ALL_STOP_IN,
  // Status, periph channel
  output logic [CNT_W-1:0]      PER_COUNT_OUT,
  output logic                  PER_RUNNING_OUT,
  output logic                  PER_UNDERFLOW_OUT,
  output logic                  PER_REFRESH_ERR_OUT,
  output logic                  PER_RESET_REQ_OUT,
  output logic                  PER_IRQ_OUT,
  // Status, independent channel
  output logic [CNT_W-1:0]      IND_COUNT_OUT,
  output logic                  IND_RUNNING_OUT,
  output logic                  IND_UNDERFLOW_OUT,
  output logic                  IND_REFRESH_ERR_OUT,
  output logic                  IND_RESET_REQ_OUT,
  output logic                  IND_IRQ_OUT
);
  logic       ind_meta_q;                         // Synchroniser first stage
  logic       ind_sync_q;                         // Synchroniser second stage
  logic       ind_prev_q;                         // Edge detect history
  logic       ind_tick;                           // Rising edge of dedicated clock
  logic       ind_hold;                           // Independent channel freeze
  logic       stop_opt_q;                         // Latched all-stop option
  logic       stop_opt_loaded_q;

  // Dedicated clock sampled in; only the second stage feeds the edge detector
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ind_meta_q <= 1'b0;
      ind_sync_q <= 1'b0;
      ind_prev_q <= 1'b0;
    end else begin
      ind_meta_q <= INDEPENDENT_WATCHDOG_CLOCK_IN;
      ind_sync_q <= ind_meta_q;
      ind_prev_q <= ind_sync_q;
    end
  end
  // Counting advances only on dedicated clock edges, never on CLK_IN rate
  assign ind_tick = ind_sync_q && !ind_prev_q;

  // Stop-on-all-stop option is a strap, caught once after reset release
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stop_opt_q        <= 1'b0;
      stop_opt_loaded_q <= 1'b0;
    end else if (!stop_opt_loaded_q) begin
      stop_opt_q        <= IND_STOP_ON_ALL_STOP_IN;
      stop_opt_loaded_q <= 1'b1;
    end
  end
  assign ind_hold = ALL_MODULE_STOP_IN && stop_opt_q;

  // Periph channel: no stop gate, frozen only by the all-stop request
  wdog_core #(.INDEP(1'b0)) u_periph_clocked_watchdog (
    .clk           (CLK_IN),
    .rst_n         (RESET_N_IN),
    .tick          (1'b1),
    .hold          (ALL_MODULE_STOP_IN),
    .refresh       (PER_REFRESH_IN),
    .pre_sel       (PER_PRE_SEL_IN),
    .tmo_sel       (PER_TMO_SEL_IN),
    .win_start_sel (PER_WIN_START_IN),
    .win_end_sel   (PER_WIN_END_IN),
    .action        (PER_ACTION_IN),
    .auto_start    (PER_AUTO_START_IN),
    .cnt_q         (PER_COUNT_OUT),
    .running_q     (PER_RUNNING_OUT),
    .underflow_q   (PER_UNDERFLOW_OUT),
    .refresh_err_q (PER_REFRESH_ERR_OUT),
    .rst_req_q     (PER_RESET_REQ_OUT),
    .irq_q         (PER_IRQ_OUT)
  );

  // Independent channel: counts dedicated clock edges
  wdog_core #(.INDEP(1'b1)) u_independent_watchdog (
    .clk           (CLK_IN),
    .rst_n         (RESET_N_IN),
    .tick          (ind_tick),
    .hold          (ind_hold),
    .refresh       (IND_REFRESH_IN),
    .pre_sel       (IND_PRE_SEL_IN),
    .tmo_sel       (IND_TMO_SEL_IN),
    .win_start_sel (IND_WIN_START_IN),
    .win_end_sel   (IND_WIN_END_IN),
    .action        (IND_ACTION_IN),
    .auto_start    (IND_AUTO_START_IN),
    .cnt_q         (IND_COUNT_OUT),
    .running_q     (IND_RUNNING_OUT),
    .underflow_q   (IND_UNDERFLOW_OUT),
    .refresh_err_q (IND_REFRESH_ERR_OUT),
    .rst_req_q     (IND_RESET_REQ_OUT),
    .irq_q         (IND_IRQ_OUT)
  );

  // Checks
  chk_ind_keeps_running: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (stop_opt_loaded_q && !stop_opt_q && ALL_MODULE_STOP_IN) |-> !ind_hold)
    else $error("independent channel halted against its option");
  chk_ind_tick_edge: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ind_tick |=> !ind_tick)
    else $error("independent tick longer than one cycle");
  cov_ind_tick: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ind_tick && IND_RUNNING_OUT);
  cov_all_stop: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ALL_MODULE_STOP_IN && PER_RUNNING_OUT);
endmodule : wdog_pair

/* bench/windowed_watchdog_timer_bench.sv */
// Self-checking bench for the peripheral-clocked and independent watchdog pair
`timescale 1ns/100ps
module windowed_watchdog_timer_bench;
  import wdog_pkg::*;
  // Clocks, reset and controls, all valued at time zero
  logic             CLK_IN = 1'b0, RESET_N_IN = 1'b0, INDEPENDENT_WATCHDOG_CLOCK_IN = 1'b0;
  logic             ALL_MODULE_STOP_IN = 1'b0, PER_REFRESH_IN = 1'b0, IND_REFRESH_IN = 1'b0;
  logic             IND_STOP_ON_ALL_STOP_IN = 1'b0;
  // Option straps, one set per channel
  logic [SEL_W-1:0] PER_PRE_SEL_IN = 3'h0, IND_PRE_SEL_IN = 3'h0;
  logic [1:0]       PER_TMO_SEL_IN = 2'h0, PER_WIN_START_IN = 2'h0, PER_WIN_END_IN = 2'h0;
  logic [1:0]       IND_TMO_SEL_IN = 2'h0, IND_WIN_START_IN = 2'h0, IND_WIN_END_IN = 2'h0;
  logic             PER_ACTION_IN = 1'b0, PER_AUTO_START_IN = 1'b1;
  logic             IND_ACTION_IN = 1'b0, IND_AUTO_START_IN = 1'b1;
  // Status outputs
  logic [CNT_W-1:0] PER_COUNT_OUT, IND_COUNT_OUT;
  logic             PER_RUNNING_OUT, PER_UNDERFLOW_OUT, PER_REFRESH_ERR_OUT;
  logic             PER_RESET_REQ_OUT, PER_IRQ_OUT;
  logic             IND_RUNNING_OUT, IND_UNDERFLOW_OUT, IND_REFRESH_ERR_OUT;
  logic             IND_RESET_REQ_OUT, IND_IRQ_OUT;
  // Action pulses gathered so one task can watch any of them
  wire logic [3:0]  pulse_v = {IND_IRQ_OUT, IND_RESET_REQ_OUT, PER_IRQ_OUT, PER_RESET_REQ_OUT};
  // Expected tables, written out from the option encodings
  int               per_ratio [6] = '{4, 64, 128, 512, 4096, 8192};
  int               ind_ratio [6] = '{1, 16, 32, 64, 128, 256};
  logic [13:0]      tmo_exp   [4] = '{14'h03FF, 14'h0FFF, 14'h1FFF, 14'h3FFF};
  int               failures = 0;     // Mismatch count
  int               checked  = 0;     // Comparison count
  int               n;                // Cycle counter for waits
  logic [13:0]      c, ci;            // Saved counter values

  wdog_pair i_dut (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .INDEPENDENT_WATCHDOG_CLOCK_IN(INDEPENDENT_WATCHDOG_CLOCK_IN),
    .ALL_MODULE_STOP_IN(ALL_MODULE_STOP_IN), .PER_REFRESH_IN(PER_REFRESH_IN),
    .IND_REFRESH_IN(IND_REFRESH_IN), .PER_PRE_SEL_IN(PER_PRE_SEL_IN),
    .PER_TMO_SEL_IN(PER_TMO_SEL_IN), .PER_WIN_START_IN(PER_WIN_START_IN),
    .PER_WIN_END_IN(PER_WIN_END_IN), .PER_ACTION_IN(PER_ACTION_IN),
    .PER_AUTO_START_IN(PER_AUTO_START_IN), .IND_PRE_SEL_IN(IND_PRE_SEL_IN),
    .IND_TMO_SEL_IN(IND_TMO_SEL_IN), .IND_WIN_START_IN(IND_WIN_START_IN),
    .IND_WIN_END_IN(IND_WIN_END_IN), .IND_ACTION_IN(IND_ACTION_IN),
    .IND_AUTO_START_IN(IND_AUTO_START_IN), .IND_STOP_ON_ALL_STOP_IN(IND_STOP_ON_ALL_STOP_IN),
    .PER_COUNT_OUT(PER_COUNT_OUT), .PER_RUNNING_OUT(PER_RUNNING_OUT),
    .PER_UNDERFLOW_OUT(PER_UNDERFLOW_OUT), .PER_REFRESH_ERR_OUT(PER_REFRESH_ERR_OUT),
    .PER_RESET_REQ_OUT(PER_RESET_REQ_OUT), .PER_IRQ_OUT(PER_IRQ_OUT),
    .IND_COUNT_OUT(IND_COUNT_OUT), .IND_RUNNING_OUT(IND_RUNNING_OUT),
    .IND_UNDERFLOW_OUT(IND_UNDERFLOW_OUT), .IND_REFRESH_ERR_OUT(IND_REFRESH_ERR_OUT),
    .IND_RESET_REQ_OUT(IND_RESET_REQ_OUT), .IND_IRQ_OUT(IND_IRQ_OUT)
  );

  // System clock, 40 ns period
  always #20 CLK_IN = ~CLK_IN;
  // Free-running dedicated clock, 220 ns period
  // The 5 ns offset keeps both of its edges off the system rising edges, so sampling never races
  initial begin
    #5;
    forever #110 INDEPENDENT_WATCHDOG_CLOCK_IN = ~INDEPENDENT_WATCHDOG_CLOCK_IN;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict, shared by the tests and the watchdog
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Step whole cycles, landing just after the rising edge
  task automatic step(input int k);
    repeat (k) begin
      @(posedge CLK_IN);
      #1;
    end
  endtask : step

  // Same straps for both channels; tests adjust singles afterwards
  task automatic opts(input logic [2:0] sel, input logic [1:0] tmo, ws, we,
                      input logic act, au);
    PER_PRE_SEL_IN = sel;
    IND_PRE_SEL_IN = sel;
    PER_TMO_SEL_IN = tmo;
    IND_TMO_SEL_IN = tmo;
    PER_WIN_START_IN = ws;
    IND_WIN_START_IN = ws;
    PER_WIN_END_IN = we;
    IND_WIN_END_IN = we;
    PER_ACTION_IN = act;
    IND_ACTION_IN = act;
    PER_AUTO_START_IN = au;
    IND_AUTO_START_IN = au;
  endtask : opts

  // Reset for 10 cycles, check reset state, release and wait for the load
  task automatic do_reset();
    RESET_N_IN = 1'b0;
    step(10);
    check(PER_COUNT_OUT, 14'h3FFF);
    check(IND_COUNT_OUT, 14'h3FFF);
    check({PER_RUNNING_OUT, PER_UNDERFLOW_OUT, IND_RUNNING_OUT, IND_UNDERFLOW_OUT}, 16'h0000);
    RESET_N_IN = 1'b1;
    step(2);
  endtask : do_reset

  // One-cycle refresh pulse on either channel
  task automatic refresh(input bit ind);
    if (ind) IND_REFRESH_IN = 1'b1;
    else PER_REFRESH_IN = 1'b1;
    step(1);
    PER_REFRESH_IN = 1'b0;
    IND_REFRESH_IN = 1'b0;
  endtask : refresh

  // Cycles between two counter steps, skipping the first partial gap
  task automatic gap(input bit ind, output int k);
    logic [13:0] v;
    int          w;
    v = ind ? IND_COUNT_OUT : PER_COUNT_OUT;
    w = 0;
    while ((ind ? IND_COUNT_OUT : PER_COUNT_OUT) === v && w < 20000) begin
      step(1);
      w++;
    end
    v = ind ? IND_COUNT_OUT : PER_COUNT_OUT;
    k = 0;
    while ((ind ? IND_COUNT_OUT : PER_COUNT_OUT) === v && k < 20000) begin
      step(1);
      k++;
    end
  endtask : gap

  // Action pulse must come within a few cycles and last exactly one
  task automatic pulse_chk(input int idx);
    int w;
    w = 0;
    while (pulse_v[idx] !== 1'b1 && w < 4) begin
      step(1);
      w++;
    end
    check(pulse_v[idx], 1'b1);
    step(1);
    check(pulse_v[idx], 1'b0);
  endtask : pulse_chk

  // Hang guard, sized at about twice the expected run
  initial begin
    #3200000;
    failures++;
    wrap_up();
  end

  // Test sequence
  initial begin
    step(1);
    // Register start: idle until the first refresh, then loads each timeout
    for (int t = 0; t < 4; t++) begin
      opts(3'h0, t[1:0], 2'h0, 2'h0, 1'b0, 1'b0);
      do_reset();
      step(8);
      check(PER_RUNNING_OUT, 1'b0);
      check(IND_RUNNING_OUT, 1'b0);
      refresh(1'b0);
      step(1);
      check(PER_RUNNING_OUT, 1'b1);
      check(PER_COUNT_OUT, tmo_exp[t]);
    end
    $display("Test start modes and timeouts done");
    // Prescaler codes 0 to 5 on both channels; independent first, it is quicker
    for (int k = 0; k < 6; k++) begin
      opts(k[2:0], 2'h3, 2'h0, 2'h0, 1'b0, 1'b1);
      do_reset();
      check(PER_RUNNING_OUT, 1'b1);
      gap(1'b1, n);
      // Quantised to system cycles, so allow one cycle either way
      check((n * 40 - ind_ratio[k] * 220) inside {[-40:40]}, 1'b1);
      gap(1'b0, n);
      check(16'(n), 16'(per_ratio[k]));
    end
    $display("Test prescaler ratios done");
    // Underflow: reset request on one channel, interrupt on the other
    opts(3'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b1);
    IND_ACTION_IN = 1'b1;
    do_reset();
    n = 0;
    while (PER_UNDERFLOW_OUT !== 1'b1 && n < 6000) begin
      step(1);
      n++;
    end
    check(n inside {[4088:4104]}, 1'b1);
    check(PER_RUNNING_OUT, 1'b0);
    check(PER_IRQ_OUT, 1'b0);
    pulse_chk(0);
    c = PER_COUNT_OUT;
    refresh(1'b0);
    step(5);
    check(PER_COUNT_OUT, c);
    n = 0;
    while (IND_UNDERFLOW_OUT !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    check(IND_UNDERFLOW_OUT, 1'b1);
    check(IND_RUNNING_OUT, 1'b0);
    pulse_chk(3);
    $display("Test underflow done");
    // Window 75 % to 100 % of timeout: early refresh legal, late one an error
    opts(3'h0, 2'h0, 2'h0, 2'h3, 1'b1, 1'b1);
    IND_WIN_START_IN = 2'h1;
    IND_ACTION_IN = 1'b0;
    do_reset();
    // Independent window starts and ends at 75 %, so it never opens and a refresh right after start is an error
    refresh(1'b1);
    pulse_chk(2);
    check(IND_REFRESH_ERR_OUT, 1'b1);
    check({IND_RUNNING_OUT, IND_IRQ_OUT, IND_UNDERFLOW_OUT}, 16'h0000);
    step(2);
    refresh(1'b0);
    step(1);
    check(PER_COUNT_OUT, 14'h03FF);
    check(PER_REFRESH_ERR_OUT, 1'b0);
    n = 0;
    while (!(PER_COUNT_OUT < 14'h0300) && n < 3000) begin
      step(1);
      n++;
    end
    refresh(1'b0);
    pulse_chk(1);
    check(PER_REFRESH_ERR_OUT, 1'b1);
    check({PER_RUNNING_OUT, PER_RESET_REQ_OUT}, 16'h0000);
    $display("Test refresh window done");
    // All-stop: periph always freezes, independent per its strap
    for (int s = 0; s < 2; s++) begin
      opts(3'h0, 2'h3, 2'h0, 2'h0, 1'b0, 1'b1);
      IND_STOP_ON_ALL_STOP_IN = s[0];
      do_reset();
      step(10);
      ALL_MODULE_STOP_IN = 1'b1;
      step(5);
      c = PER_COUNT_OUT;
      ci = IND_COUNT_OUT;
      step(30);
      check(PER_COUNT_OUT, c);
      check(PER_RUNNING_OUT, 1'b1);
      check(IND_COUNT_OUT === ci, s[0]);
      ALL_MODULE_STOP_IN = 1'b0;
      step(10);
      check(PER_COUNT_OUT !== c, 1'b1);
    end
    $display("Test all-module stop done");
    wrap_up();
  end
endmodule : windowed_watchdog_timer_bench
